// ---- src/cfg_window_pkg.sv ----
// Shared constants and carrier types for the configuration window and legacy register layout
package cfg_window_pkg;

  // Legacy header byte offsets in the BAR0 I/O region
  localparam logic [7:0] LEG_OFFERED_FEAT   = 8'h00;
  localparam logic [7:0] LEG_ACCEPTED_FEAT  = 8'h04;
  localparam logic [7:0] LEG_RING_BASE      = 8'h08;
  localparam logic [7:0] LEG_RING_DEPTH     = 8'h0c;
  localparam logic [7:0] LEG_RING_INDEX     = 8'h0e;
  localparam logic [7:0] LEG_RING_KICK      = 8'h10;
  localparam logic [7:0] LEG_DEVICE_STATE   = 8'h12;
  localparam logic [7:0] LEG_IRQ_CAUSE      = 8'h13;
  localparam logic [7:0] LEG_CONFIG_VECTOR  = 8'h14;
  localparam logic [7:0] LEG_RING_VECTOR    = 8'h16;
  localparam logic [7:0] LEG_DEVCFG_PLAIN   = 8'h14;
  localparam logic [7:0] LEG_DEVCFG_VECTORS = 8'h18;

  // Reset values
  localparam logic [7:0]  STATE_RESET = 8'h00;
  localparam logic [15:0] NO_VECTOR   = 16'hffff;

  // Interrupt cause bit positions
  localparam int CAUSE_RING   = 0;
  localparam int CAUSE_CONFIG = 1;

  // Configuration-access capability dword indices inside the capability
  localparam logic [2:0] CAP_DW_HEADER  = 3'h0;
  localparam logic [2:0] CAP_DW_BAR     = 3'h1;
  localparam logic [2:0] CAP_DW_OFFSET  = 3'h2;
  localparam logic [2:0] CAP_DW_LENGTH  = 3'h3;
  localparam logic [2:0] CAP_DW_PAYLOAD = 3'h4;

  // Capability header bytes
  localparam logic [7:0] CAP_VENDOR_ID = 8'h09;
  localparam logic [7:0] CAP_LENGTH    = 8'h14;
  localparam logic [7:0] CAP_TYPE_WIN  = 8'h05;

  // Legal access sizes and the size of the I/O region address space
  localparam logic [2:0] SIZE_BYTE  = 3'h1;
  localparam logic [2:0] SIZE_HALF  = 3'h2;
  localparam logic [2:0] SIZE_WORD  = 3'h4;
  localparam int         REGION_MAX = 256;

  // One access presented to the shared register engine
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [2:0]  size;
    logic [31:0] wdata;
  } access_s;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_BRIDGE = 2'b01,
    ST_DONE   = 2'b10
  } win_state_e;

endpackage : cfg_window_pkg

// ---- src/devcfg_store.sv ----
// Byte-addressed store for the device-specific configuration region
`timescale 1ns/1ns
`default_nettype none
module devcfg_store #(
  parameter int DEPTH = 64
) (
  input  wire logic            i_clk,
  input  wire logic [3:0]      i_wr_en,
  input  wire logic [3:0][7:0] i_wr_addr,
  input  wire logic [3:0][7:0] i_wr_data,
  input  wire logic            i_load_en,
  input  wire logic [7:0]      i_load_addr,
  input  wire logic [7:0]      i_load_data,
  input  wire logic [3:0][7:0] i_rd_addr,
  output logic      [3:0][7:0] o_rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [7:0] mem_q [DEPTH];

  // Host lanes come last so they win over a device load to the same byte
  always_ff @(posedge i_clk)
  begin
    if (i_load_en && (int'(i_load_addr) < DEPTH))
      mem_q[i_load_addr[AW-1:0]] <= i_load_data;
    for (int l = 0; l < 4; l++)
    begin
      if (i_wr_en[l] && (int'(i_wr_addr[l]) < DEPTH))
        mem_q[i_wr_addr[l][AW-1:0]] <= i_wr_data[l];
    end
  end

  // Bytes past the end read as zero
  always_comb
  begin
    for (int l = 0; l < 4; l++)
      o_rd_data[l] = (int'(i_rd_addr[l]) < DEPTH) ? mem_q[i_rd_addr[l][AW-1:0]] : 8'h00;
  end

endmodule : devcfg_store
`default_nettype wire

// ---- src/cfg_window_legacy.sv ----
// Configuration-access window and legacy I/O register layout of the device
`timescale 1ns/1ns
`default_nettype none
module cfg_window_legacy
  import cfg_window_pkg::*;
#(
  parameter int          NUM_RINGS        = 2,
  parameter logic [15:0] RING_DEPTH       = 16'h0100,
  parameter logic [31:0] OFFERED_FEATURES = 32'h0000_0000,
  parameter int          DEVCFG_BYTES     = 64,
  parameter bit          NON_TRANSITIONAL = 1'b0,
  parameter logic [7:0]  WINDOW_BAR       = 8'h00,
  parameter logic [7:0]  CAP_NEXT         = 8'h00
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Configuration-space port for the access capability
  input  wire logic        i_cfg_req,
  input  wire logic        i_cfg_wr,
  input  wire logic [2:0]  i_cfg_dw,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic             o_cfg_ack,
  output logic [31:0]      o_cfg_rdata,
  // BAR0 I/O port
  input  wire logic        i_io_req,
  input  wire logic        i_io_wr,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic [2:0]  i_io_size,
  input  wire logic [31:0] i_io_wdata,
  output logic             o_io_ack,
  output logic [31:0]      o_io_rdata,
  // Device-side events and state
  input  wire logic        i_msix_en,
  input  wire logic        i_ring_event,
  input  wire logic        i_config_event,
  input  wire logic        i_devcfg_load,
  input  wire logic [7:0]  i_devcfg_addr,
  input  wire logic [7:0]  i_devcfg_data,
  output logic             o_intx,
  output logic             o_ring_kick,
  output logic [15:0]      o_kick_index,
  output logic [7:0]       o_device_state,
  output logic [63:0]      o_accepted_features,
  output logic             o_device_reset,
  output logic             o_bars_silenced
);
  localparam int QW = (NUM_RINGS > 1) ? $clog2(NUM_RINGS) : 1;

  // Window registers
  win_state_e  state_q;
  logic        win_wr_q;
  logic [7:0]  win_bar_q;
  logic [31:0] win_off_q;
  logic [31:0] win_len_q;
  logic [31:0] payload_q;
  logic        cfg_ack_q;
  logic [31:0] cfg_rdata_q;

  // Legacy registers
  logic [31:0] accepted_q;
  logic [15:0] ring_index_q;
  logic [15:0] kick_q;
  logic [7:0]  state_reg_q;
  logic [7:0]  cause_q;
  logic [15:0] config_vec_q;
  logic [31:0] ring_base_q [NUM_RINGS];
  logic [15:0] ring_vec_q  [NUM_RINGS];
  logic        soft_rst_q;
  logic        silenced_q;
  logic        io_ack_q;
  logic [31:0] io_rdata_q;
  logic        kick_pulse_q;
  logic        intx_q;

  // Shared engine
  access_s         req;
  logic            win_turn;
  logic            win_ok;
  logic            io_take;
  logic            go;
  logic [7:0]      dev_base;
  logic [3:0][7:0] lane_a;
  logic [3:0][7:0] lane_w;
  logic [3:0]      lane_on;
  logic [3:0]      lane_hdr;
  logic [3:0]      wr_lane;
  logic [3:0]      mem_wr_en;
  logic [3:0][7:0] mem_addr;
  logic [3:0][7:0] mem_rd;
  logic [3:0][7:0] hdr_rd;
  logic [31:0]     eng_rdata;
  logic            ring_ok;
  logic [QW-1:0]   ring_sel;
  logic [15:0]     ring_depth;
  logic [31:0]     sel_ring_base;
  logic [15:0]     sel_ring_vec;
  logic            cause_read;
  logic [1:0]      cause_set;
  logic [7:0]      cause_d;
  logic            state_zero_wr;
  logic            silence_wr;
  logic            kick_wr;
  logic            cfg_new;
  logic [31:0]     cap_rd;
  logic [31:0]     be_mask;

  // Window has the engine while bridging; the I/O port waits its turn
  assign win_turn = (state_q == ST_BRIDGE);
  assign win_ok   = (win_bar_q == WINDOW_BAR) && (win_off_q < 32'(REGION_MAX)) &&
                    ((win_len_q == 32'(SIZE_BYTE)) || (win_len_q == 32'(SIZE_HALF)) ||
                     (win_len_q == 32'(SIZE_WORD)));
  assign io_take  = !win_turn && i_io_req && !io_ack_q;
  assign go       = win_turn ? win_ok : io_take;
  assign req      = win_turn ? access_s'{wr: win_wr_q, addr: win_off_q[7:0], size: win_len_q[2:0], wdata: payload_q}
                             : access_s'{wr: i_io_wr, addr: i_io_addr, size: i_io_size, wdata: i_io_wdata};

  // Device region moves with MSI-X; both starts are dword aligned
  assign dev_base = i_msix_en ? LEG_DEVCFG_VECTORS : LEG_DEVCFG_PLAIN;

  // Queue-indexed fields follow the selected ring
  assign ring_ok       = ({16'h0, ring_index_q} < 32'(NUM_RINGS));
  assign ring_sel      = ring_index_q[QW-1:0];
  assign ring_depth    = ring_ok ? RING_DEPTH : 16'h0000;
  assign sel_ring_base = ring_ok ? ring_base_q[ring_sel] : 32'h0;
  assign sel_ring_vec  = ring_ok ? ring_vec_q[ring_sel] : NO_VECTOR;

  // Per-lane addressing: lane l is byte addr+l, lanes beyond size are idle
  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      lane_a[l]    = req.addr + 8'(l);
      lane_w[l]    = req.wdata[8*l +: 8];
      lane_on[l]   = go && (3'(l) < req.size);
      lane_hdr[l]  = (lane_a[l] < dev_base);
      wr_lane[l]   = lane_on[l] && req.wr && !silenced_q;
      mem_wr_en[l] = wr_lane[l] && !lane_hdr[l];
      mem_addr[l]  = lane_a[l] - dev_base;
    end
  end

  // Header byte map, little-endian within each field
  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      case (lane_a[l]) inside
        [8'h00:8'h03]: hdr_rd[l] = OFFERED_FEATURES[8*lane_a[l][1:0] +: 8];
        [8'h04:8'h07]: hdr_rd[l] = accepted_q[8*lane_a[l][1:0] +: 8];
        [8'h08:8'h0b]: hdr_rd[l] = sel_ring_base[8*lane_a[l][1:0] +: 8];
        [8'h0c:8'h0d]: hdr_rd[l] = ring_depth[8*lane_a[l][0] +: 8];
        [8'h0e:8'h0f]: hdr_rd[l] = ring_index_q[8*lane_a[l][0] +: 8];
        [8'h10:8'h11]: hdr_rd[l] = kick_q[8*lane_a[l][0] +: 8];
        LEG_DEVICE_STATE: hdr_rd[l] = state_reg_q;
        LEG_IRQ_CAUSE:    hdr_rd[l] = cause_q;
        [8'h14:8'h15]: hdr_rd[l] = config_vec_q[8*lane_a[l][0] +: 8];
        [8'h16:8'h17]: hdr_rd[l] = sel_ring_vec[8*lane_a[l][0] +: 8];
        default:       hdr_rd[l] = 8'h00;
      endcase
    end
  end

  // Device region bytes come from a byte image, so any width reads the same bytes
  always_comb
  begin
    eng_rdata = 32'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (lane_on[l] && !silenced_q)
        eng_rdata[8*l +: 8] = lane_hdr[l] ? hdr_rd[l] : mem_rd[l];
    end
  end

  devcfg_store #(
    .DEPTH       (DEVCFG_BYTES)
  ) u_devcfg (
    .i_clk       (i_clk),
    .i_wr_en     (mem_wr_en),
    .i_wr_addr   (mem_addr),
    .i_wr_data   (lane_w),
    .i_load_en   (i_devcfg_load),
    .i_load_addr (i_devcfg_addr),
    .i_load_data (i_devcfg_data),
    .i_rd_addr   (mem_addr),
    .o_rd_data   (mem_rd)
  );

  // Side effects of engine accesses
  always_comb
  begin
    cause_read    = 1'b0;
    state_zero_wr = 1'b0;
    kick_wr       = 1'b0;
    for (int l = 0; l < 4; l++)
    begin
      if (lane_on[l] && !req.wr && lane_hdr[l] && (lane_a[l] == LEG_IRQ_CAUSE) && !silenced_q)
        cause_read = 1'b1;
      if (wr_lane[l] && lane_hdr[l] && (lane_a[l] == LEG_DEVICE_STATE) && (lane_w[l] == STATE_RESET))
        state_zero_wr = 1'b1;
      if (wr_lane[l] && lane_hdr[l] && (lane_a[l][7:1] == LEG_RING_KICK[7:1]))
        kick_wr = 1'b1;
    end
  end

  assign silence_wr = NON_TRANSITIONAL && go && req.wr && (req.size == SIZE_BYTE) &&
                      (req.addr == LEG_DEVICE_STATE) && (req.wdata[7:0] == STATE_RESET);
  // Causes only gather while line interrupts are in use; a new event beats the read clear
  assign cause_set  = {i_config_event, i_ring_event} & {2{!i_msix_en}};
  assign cause_d    = (cause_read ? 8'h00 : cause_q) | {6'h0, cause_set};

  // Legacy register file; a zero status write (bar a non-transitional byte write) clears it on the second edge, one edge after o_device_reset rises
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b || soft_rst_q)
    begin
      accepted_q   <= 32'h0;
      ring_index_q <= 16'h0;
      kick_q       <= 16'h0;
      state_reg_q  <= STATE_RESET;
      cause_q      <= 8'h00;
      config_vec_q <= NO_VECTOR;
      for (int q = 0; q < NUM_RINGS; q++)
      begin
        ring_base_q[q] <= 32'h0;
        ring_vec_q[q]  <= NO_VECTOR;
      end
    end
    else
    begin
      cause_q <= cause_d;
      for (int l = 0; l < 4; l++)
      begin
        if (wr_lane[l] && lane_hdr[l])
        begin
          case (lane_a[l]) inside
            [8'h04:8'h07]: accepted_q[8*lane_a[l][1:0] +: 8] <= lane_w[l];
            [8'h08:8'h0b]:
              if (ring_ok)
                ring_base_q[ring_sel][8*lane_a[l][1:0] +: 8] <= lane_w[l];
            [8'h0e:8'h0f]: ring_index_q[8*lane_a[l][0] +: 8] <= lane_w[l];
            [8'h10:8'h11]: kick_q[8*lane_a[l][0] +: 8] <= lane_w[l];
            LEG_DEVICE_STATE: state_reg_q <= lane_w[l];
            [8'h14:8'h15]: config_vec_q[8*lane_a[l][0] +: 8] <= lane_w[l];
            [8'h16:8'h17]:
              if (ring_ok)
                ring_vec_q[ring_sel][8*lane_a[l][0] +: 8] <= lane_w[l];
            default: ;
          endcase
        end
      end
    end
  end

  // Pulses, line interrupt and the fail-safe latch
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      soft_rst_q   <= 1'b0;
      silenced_q   <= 1'b0;
      kick_pulse_q <= 1'b0;
      intx_q       <= 1'b0;
      io_ack_q     <= 1'b0;
      io_rdata_q   <= 32'h0;
    end
    else
    begin
      soft_rst_q   <= state_zero_wr && !silence_wr;
      silenced_q   <= silenced_q || silence_wr;
      kick_pulse_q <= kick_wr;
      intx_q       <= !i_msix_en && (cause_d != 8'h00);
      io_ack_q     <= io_take;
      if (io_take)
        io_rdata_q <= eng_rdata;
    end
  end

  // Capability config reads; header dword is read-only
  assign be_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  assign cfg_new = i_cfg_req && !cfg_ack_q && (state_q == ST_IDLE);
  always_comb
  begin
    case (i_cfg_dw)
      CAP_DW_HEADER:  cap_rd = {CAP_TYPE_WIN, CAP_LENGTH, CAP_NEXT, CAP_VENDOR_ID};
      CAP_DW_BAR:     cap_rd = {24'h0, win_bar_q};
      CAP_DW_OFFSET:  cap_rd = win_off_q;
      CAP_DW_LENGTH:  cap_rd = win_len_q;
      CAP_DW_PAYLOAD: cap_rd = payload_q;
      default:        cap_rd = 32'h0;
    endcase
  end

  // Window sequencer: payload accesses bridge one cycle, then answer
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      state_q     <= ST_IDLE;
      win_wr_q    <= 1'b0;
      win_bar_q   <= 8'h00;
      win_off_q   <= 32'h0;
      win_len_q   <= 32'h0;
      payload_q   <= 32'h0;
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= 32'h0;
    end
    else
    begin
      cfg_ack_q <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (cfg_new)
          begin
            if (i_cfg_dw == CAP_DW_PAYLOAD)
            begin
              win_wr_q <= i_cfg_wr;
              if (i_cfg_wr)
                payload_q <= (payload_q & ~be_mask) | (i_cfg_wdata & be_mask);
              state_q <= ST_BRIDGE;
            end
            else
            begin
              if (i_cfg_wr && (i_cfg_dw == CAP_DW_BAR) && i_cfg_be[0])
                win_bar_q <= i_cfg_wdata[7:0];
              if (i_cfg_wr && (i_cfg_dw == CAP_DW_OFFSET))
                win_off_q <= (win_off_q & ~be_mask) | (i_cfg_wdata & be_mask);
              if (i_cfg_wr && (i_cfg_dw == CAP_DW_LENGTH))
                win_len_q <= (win_len_q & ~be_mask) | (i_cfg_wdata & be_mask);
              cfg_rdata_q <= i_cfg_wr ? 32'h0 : cap_rd;
              cfg_ack_q   <= 1'b1;
            end
          end
        ST_BRIDGE:
        begin
          // Only the leading length bytes are replaced on a read
          if (!win_wr_q && win_ok)
          begin
            for (int l = 0; l < 4; l++)
            begin
              if (3'(l) < win_len_q[2:0])
                payload_q[8*l +: 8] <= eng_rdata[8*l +: 8];
            end
          end
          state_q <= ST_DONE;
        end
        ST_DONE:
        begin
          cfg_rdata_q <= win_wr_q ? 32'h0 : payload_q;
          cfg_ack_q   <= 1'b1;
          state_q     <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign o_cfg_ack           = cfg_ack_q;
  assign o_cfg_rdata         = cfg_rdata_q;
  assign o_io_ack            = io_ack_q;
  assign o_io_rdata          = io_rdata_q;
  assign o_intx              = intx_q;
  assign o_ring_kick         = kick_pulse_q;
  assign o_kick_index        = kick_q;
  assign o_device_state      = state_reg_q;
  assign o_accepted_features = {32'h0, accepted_q};
  assign o_device_reset      = soft_rst_q;
  assign o_bars_silenced     = silenced_q;

endmodule : cfg_window_legacy
`default_nettype wire

// ---- tb/cfg_window_legacy_chk.sv ----
// Port assertions for the configuration window and legacy register layout
`timescale 1ns/1ns
`default_nettype none
module cfg_window_legacy_chk
  import cfg_window_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_cfg_req,
  input  wire logic [2:0]  i_cfg_dw,
  input  wire logic        o_cfg_ack,
  input  wire logic        i_io_req,
  input  wire logic        i_io_wr,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic        o_io_ack,
  input  wire logic [31:0] o_io_rdata,
  input  wire logic        i_msix_en,
  input  wire logic        i_ring_event,
  input  wire logic        i_config_event,
  input  wire logic        o_intx,
  input  wire logic [7:0]  o_device_state,
  input  wire logic [63:0] o_accepted_features,
  input  wire logic        o_device_reset,
  input  wire logic        o_bars_silenced
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_io_ack_time: assert property ($rose(i_io_req) |-> ##[1:2] o_io_ack)
    else $error("io ack missing");
  a_cfg_ack_plain: assert property ($rose(i_cfg_req) && i_cfg_dw != CAP_DW_PAYLOAD |=> o_cfg_ack)
    else $error("cfg ack missing");
  a_cfg_ack_bridge: assert property ($rose(i_cfg_req) && i_cfg_dw == CAP_DW_PAYLOAD |-> ##3 o_cfg_ack)
    else $error("bridged ack not on third cycle");
  a_intx_msix_off: assert property (i_msix_en && $past(i_msix_en) |-> !o_intx)
    else $error("legacy interrupt under msix");
  // Same-cycle events legitimately win over the clear
  a_cause_read_clear: assert property (o_io_ack && !i_io_wr && i_io_addr == LEG_IRQ_CAUSE
    && !$past(i_ring_event) && !$past(i_config_event) |-> !o_intx)
    else $error("interrupt kept after cause read");
  a_reset_clears_regs: assert property (o_device_reset |=> o_device_state == STATE_RESET
    && o_accepted_features == 64'h0)
    else $error("soft reset left state");
  a_feat_upper_zero: assert property (o_accepted_features[63:32] == 32'h0)
    else $error("upper features accepted");
  a_silence_sticky: assert property (o_bars_silenced |=> o_bars_silenced)
    else $error("fail-safe released");
  a_silent_read_zero: assert property (o_io_ack && !i_io_wr && $past(o_bars_silenced, 2)
    |-> o_io_rdata == 32'h0)
    else $error("silenced read not zero");
endmodule : cfg_window_legacy_chk

bind cfg_window_legacy cfg_window_legacy_chk i_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_req(i_cfg_req), .i_cfg_dw(i_cfg_dw),
  .o_cfg_ack(o_cfg_ack), .i_io_req(i_io_req), .i_io_wr(i_io_wr), .i_io_addr(i_io_addr),
  .o_io_ack(o_io_ack), .o_io_rdata(o_io_rdata), .i_msix_en(i_msix_en),
  .i_ring_event(i_ring_event), .i_config_event(i_config_event), .o_intx(o_intx),
  .o_device_state(o_device_state), .o_accepted_features(o_accepted_features),
  .o_device_reset(o_device_reset), .o_bars_silenced(o_bars_silenced)
);
`default_nettype wire

// ---- tb/host_drv.sv ----
// Host driver model issuing configuration and legacy I/O cycles
`timescale 1ns/1ns
`default_nettype none
module host_drv
  import cfg_window_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_cfg_ack,
  input  wire logic [31:0] i_cfg_rdata,
  input  wire logic        i_io_ack,
  input  wire logic [31:0] i_io_rdata,
  output var  logic        o_cfg_req,
  output var  logic        o_cfg_wr,
  output var  logic [2:0]  o_cfg_dw,
  output var  logic [31:0] o_cfg_wdata,
  output var  logic        o_io_req,
  output var  access_s     o_io
);
  initial
  begin
    o_cfg_req   = 1'b0;
    o_cfg_wr    = 1'b0;
    o_cfg_dw    = 3'h0;
    o_cfg_wdata = 32'h0;
    o_io_req    = 1'b0;
    o_io        = '0;
  end

  // Released qualifiers flip so stale values never look valid
  task automatic io(input logic wr, input logic [7:0] a, input logic [2:0] s,
                    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    o_io_req <= 1'b1;
    o_io     <= '{wr: wr, addr: a, size: s, wdata: wd};
    // A lost ack hangs here so the bench timeout fails the run
    do @(posedge i_clk); while (i_io_ack !== 1'b1);
    rd = i_io_rdata;
    o_io_req <= 1'b0;
    o_io     <= ~o_io;
  endtask : io

  task automatic cfg(input logic wr, input logic [2:0] dw, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge i_clk);
    o_cfg_req   <= 1'b1;
    o_cfg_wr    <= wr;
    o_cfg_dw    <= dw;
    o_cfg_wdata <= wd;
    do @(posedge i_clk); while (i_cfg_ack !== 1'b1);
    rd = i_cfg_rdata;
    o_cfg_req   <= 1'b0;
    o_cfg_wdata <= ~wd;
  endtask : cfg
endmodule : host_drv
`default_nettype wire

// ---- tb/cfg_window_legacy_test.sv ----
// Self-checking bench for the configuration window and legacy register layout
`timescale 1ns/1ns
`default_nettype none
module cfg_window_legacy_test
  import cfg_window_pkg::*;
;
  localparam logic [31:0] OFFER = 32'h1234_5678;
  localparam logic [15:0] DEPTH = 16'h0100;
  logic        clk = 1'b0, rst_b = 1'b0, msix = 1'b0, ring_ev = 1'b0, cfg_ev = 1'b0;
  logic        ld = 1'b0, cfg_req, cfg_wr, cfg_ack, io_req, io_ack, intx, kick, dev_rst, silenced;
  logic [7:0]  ld_addr = 8'h0, ld_data = 8'h0, dev_state;
  logic [2:0]  cfg_dw;
  logic [31:0] cfg_wdata, cfg_rdata, io_rdata, kick_last = 32'h0;
  logic [15:0] kick_idx;
  logic [63:0] feats;
  access_s     io;
  int          failures = 0, check_count = 0, cycles = 0, kicks = 0, resets = 0;

  always #10 clk = ~clk;

  // Non-transitional build so the fail-safe path can be reached
  cfg_window_legacy #(.RING_DEPTH(DEPTH), .OFFERED_FEATURES(OFFER), .NON_TRANSITIONAL(1'b1)) i_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_cfg_req(cfg_req), .i_cfg_wr(cfg_wr), .i_cfg_dw(cfg_dw),
    .i_cfg_be(4'hf), .i_cfg_wdata(cfg_wdata), .o_cfg_ack(cfg_ack), .o_cfg_rdata(cfg_rdata),
    .i_io_req(io_req), .i_io_wr(io.wr), .i_io_addr(io.addr), .i_io_size(io.size),
    .i_io_wdata(io.wdata), .o_io_ack(io_ack), .o_io_rdata(io_rdata), .i_msix_en(msix),
    .i_ring_event(ring_ev), .i_config_event(cfg_ev), .i_devcfg_load(ld), .i_devcfg_addr(ld_addr),
    .i_devcfg_data(ld_data), .o_intx(intx), .o_ring_kick(kick), .o_kick_index(kick_idx),
    .o_device_state(dev_state), .o_accepted_features(feats), .o_device_reset(dev_rst),
    .o_bars_silenced(silenced));

  host_drv i_host (
    .i_clk(clk), .i_cfg_ack(cfg_ack), .i_cfg_rdata(cfg_rdata), .i_io_ack(io_ack),
    .i_io_rdata(io_rdata), .o_cfg_req(cfg_req), .o_cfg_wr(cfg_wr), .o_cfg_dw(cfg_dw),
    .o_cfg_wdata(cfg_wdata), .o_io_req(io_req), .o_io(io));

  always @(posedge clk)
  begin
    cycles++;
    if (kick === 1'b1)
    begin
      kicks++;
      kick_last = {16'h0, kick_idx};
    end
    if (dev_rst === 1'b1)
      resets++;
    if (cycles == 3000)
    begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [2:0] s, input logic [31:0] exp);
    logic [31:0] d;
    i_host.io(1'b0, a, s, 32'h0, d);
    chk(d, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [2:0] s, input logic [31:0] v);
    logic [31:0] d;
    i_host.io(1'b1, a, s, v, d);
  endtask : wr

  task automatic cr(input logic [2:0] dw, input logic [31:0] exp);
    logic [31:0] d;
    i_host.cfg(1'b0, dw, 32'h0, d);
    chk(d, exp);
  endtask : cr

  task automatic cw(input logic [2:0] dw, input logic [31:0] v);
    logic [31:0] d;
    i_host.cfg(1'b1, dw, v, d);
  endtask : cw

  task automatic event_pulse(input logic cfg_sel);
    @(posedge clk);
    ring_ev <= ~cfg_sel;
    cfg_ev  <= cfg_sel;
    @(posedge clk);
    ring_ev <= 1'b0;
    cfg_ev  <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : event_pulse

  task automatic final_report;
    $display("Checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(LEG_OFFERED_FEAT, SIZE_WORD, OFFER);
    rd(LEG_DEVICE_STATE, SIZE_BYTE, 32'h0);
    rd(LEG_RING_DEPTH, SIZE_HALF, {16'h0, DEPTH});
    wr(LEG_OFFERED_FEAT, SIZE_WORD, 32'hffff_ffff);
    rd(LEG_OFFERED_FEAT, SIZE_WORD, OFFER);
    wr(LEG_ACCEPTED_FEAT, SIZE_WORD, 32'ha5a5_5a5a);
    rd(LEG_ACCEPTED_FEAT, SIZE_WORD, 32'ha5a5_5a5a);
    rd(LEG_ACCEPTED_FEAT + 8'h01, SIZE_BYTE, 32'h5a);
    chk(feats[63:32], 32'h0);
    wr(LEG_RING_BASE, SIZE_WORD, 32'h0001_2345);
    rd(LEG_RING_BASE, SIZE_WORD, 32'h0001_2345);
    wr(LEG_RING_INDEX, SIZE_HALF, 32'h2);
    rd(LEG_RING_INDEX, SIZE_HALF, 32'h2);
    rd(LEG_RING_DEPTH, SIZE_HALF, 32'h0);
    wr(LEG_RING_KICK, SIZE_HALF, 32'h1);
    repeat (2) @(posedge clk);
    chk(kicks, 32'h1);
    chk(kick_last, 32'h1);
    $display("test header done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      ld      <= 1'b1;
      ld_addr <= 8'(k);
      ld_data <= 8'(17 * (k + 1));
    end
    @(posedge clk);
    ld <= 1'b0;
    rd(LEG_DEVCFG_PLAIN, SIZE_WORD, 32'h4433_2211);
    rd(LEG_DEVCFG_PLAIN + 8'h01, SIZE_BYTE, 32'h22);
    rd(LEG_DEVCFG_PLAIN + 8'h02, SIZE_HALF, 32'h4433);
    msix <= 1'b1;
    rd(LEG_CONFIG_VECTOR, SIZE_HALF, {16'h0, NO_VECTOR});
    rd(LEG_RING_VECTOR, SIZE_HALF, {16'h0, NO_VECTOR});
    wr(LEG_CONFIG_VECTOR, SIZE_HALF, 32'h3);
    rd(LEG_CONFIG_VECTOR, SIZE_HALF, 32'h3);
    rd(LEG_DEVCFG_VECTORS, SIZE_WORD, 32'h4433_2211);
    msix <= 1'b0;
    rd(LEG_DEVCFG_PLAIN, SIZE_BYTE, 32'h11);
    $display("test layout done");
    event_pulse(1'b0);
    chk({31'h0, intx}, 32'h1);
    rd(LEG_IRQ_CAUSE, SIZE_BYTE, 32'h1);
    chk({31'h0, intx}, 32'h0);
    rd(LEG_IRQ_CAUSE, SIZE_BYTE, 32'h0);
    event_pulse(1'b1);
    rd(LEG_IRQ_CAUSE, SIZE_BYTE, 32'h2);
    $display("test cause done");
    cw(CAP_DW_BAR, 32'h0);
    cw(CAP_DW_LENGTH, {29'h0, SIZE_WORD});
    cw(CAP_DW_OFFSET, 32'h4);
    cr(CAP_DW_LENGTH, 32'h4);
    cr(CAP_DW_OFFSET, 32'h4);
    cr(CAP_DW_HEADER, {CAP_TYPE_WIN, CAP_LENGTH, 8'h00, CAP_VENDOR_ID});
    cr(CAP_DW_PAYLOAD, 32'ha5a5_5a5a);
    cw(CAP_DW_LENGTH, {29'h0, SIZE_HALF});
    cw(CAP_DW_OFFSET, 32'he);
    cw(CAP_DW_PAYLOAD, 32'hbeef_0001);
    rd(LEG_RING_INDEX, SIZE_HALF, 32'h1);
    wr(LEG_DEVICE_STATE, SIZE_BYTE, 32'h7);
    chk({24'h0, dev_state}, 32'h7);
    cw(CAP_DW_LENGTH, {29'h0, SIZE_BYTE});
    cw(CAP_DW_OFFSET, 32'h12);
    cr(CAP_DW_PAYLOAD, 32'hbeef_0007);
    cw(CAP_DW_BAR, 32'h1);
    cr(CAP_DW_BAR, 32'h1);
    // Foreign BAR: the bridged write must not reach the status byte
    cw(CAP_DW_PAYLOAD, 32'hbeef_0009);
    chk({24'h0, dev_state}, 32'h7);
    cw(CAP_DW_BAR, 32'h0);
    $display("test window done");
    wr(LEG_DEVICE_STATE, SIZE_HALF, 32'h0);
    repeat (2) @(posedge clk);
    chk(resets, 32'h1);
    rd(LEG_ACCEPTED_FEAT, SIZE_WORD, 32'h0);
    rd(LEG_DEVICE_STATE, SIZE_BYTE, 32'h0);
    cr(CAP_DW_OFFSET, 32'h12);
    wr(LEG_DEVICE_STATE, SIZE_BYTE, 32'h5);
    wr(LEG_DEVICE_STATE, SIZE_BYTE, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, silenced}, 32'h1);
    chk(resets, 32'h1);
    rd(LEG_OFFERED_FEAT, SIZE_WORD, 32'h0);
    wr(LEG_RING_BASE, SIZE_WORD, 32'h55);
    // Reads are zeroed anyway, so the dropped write shows on the feature port
    wr(LEG_ACCEPTED_FEAT, SIZE_WORD, 32'h55);
    chk(feats[31:0], 32'h0);
    rd(LEG_RING_BASE, SIZE_WORD, 32'h0);
    cr(CAP_DW_PAYLOAD, 32'hbeef_0000);
    $display("test fail-safe done");
    final_report();
  end
endmodule : cfg_window_legacy_test
`default_nettype wire
